// ---- inc/memmap_pkg.sv ----
// constants for the 64 KB bus address decoder: region bounds, register addresses, reset timing
// assumes an 8-bit core issuing 16-bit byte addresses with separate read and write strobes
package memmap_pkg;

  localparam int unsigned     ADDR_W          = 16;

  // region bounds, inclusive
  localparam logic [15:0]     IO_BASE         = 16'h0000;
  localparam logic [15:0]     IO_END          = 16'h003F;
  localparam logic [15:0]     RAM_BASE        = 16'h0080;
  localparam logic [15:0]     RAM_END         = 16'h00FF;
  localparam logic [15:0]     FLASH_BASE      = 16'h7800;
  localparam logic [15:0]     FLASH_END       = 16'h7FEE;
  localparam logic [15:0]     TRIM_ADDR       = 16'h7FEF;
  localparam logic [15:0]     MONROM_BASE     = 16'hF000;
  localparam logic [15:0]     MONROM_END      = 16'hF2EF;
  localparam logic [15:0]     MONROM2_BASE    = 16'hFEF0;
  localparam logic [15:0]     MONROM2_END     = 16'hFEFF;
  localparam logic [15:0]     VECTOR_BASE     = 16'hFFF2;
  localparam logic [15:0]     VECTOR_END      = 16'hFFFF;

  // reserved locations: defined as legal, behaviour undefined
  localparam logic [15:0]     RSVD_A_BASE     = 16'hFE03;
  localparam logic [15:0]     RSVD_A_END      = 16'hFE06;
  localparam logic [15:0]     RSVD_B_ADDR     = 16'hFE09;
  localparam logic [15:0]     RSVD_C_ADDR     = 16'hFFF1;

  // region sizes
  localparam int unsigned     RAM_BYTES       = 128;
  localparam int unsigned     FLASH_BYTES     = 2031;
  localparam int unsigned     MONROM_LO_BYTES = 752;
  localparam int unsigned     MONROM_BYTES    = 768;
  localparam int unsigned     VECTOR_BYTES    = 14;

  // offset widths handed to the selected array
  localparam int unsigned     RAM_OFS_W       = 7;
  localparam int unsigned     FLASH_OFS_W     = 11;
  localparam int unsigned     MONROM_OFS_W    = 10;
  localparam int unsigned     VECTOR_OFS_W    = 4;

  // high-page system registers, index order of sysreg_idx
  localparam int unsigned     SYSREG_NUM      = 10;
  localparam int unsigned     SYSREG_IDX_W    = 4;
  localparam logic [3:0]      IDX_BREAK_STATUS   = 4'h0;
  localparam logic [3:0]      IDX_RESET_STATUS   = 4'h1;
  localparam logic [3:0]      IDX_BREAK_FLAG_CTL = 4'h2;
  localparam logic [3:0]      IDX_FLASH_CTL      = 4'h3;
  localparam logic [3:0]      IDX_BRKPT_HIGH     = 4'h4;
  localparam logic [3:0]      IDX_BRKPT_LOW      = 4'h5;
  localparam logic [3:0]      IDX_BRKPT_STATCTL  = 4'h6;
  localparam logic [3:0]      IDX_LOWV_STATUS    = 4'h7;
  localparam logic [3:0]      IDX_FLASH_PROTECT  = 4'h8;
  localparam logic [3:0]      IDX_WDOG_CTL       = 4'h9;
  localparam logic [15:0]     SYSREG_ADDR [SYSREG_NUM] = '{
    16'hFE00, 16'hFE01, 16'hFE02, 16'hFE08, 16'hFE0C,
    16'hFE0D, 16'hFE0E, 16'hFE0F, 16'hFFF0, 16'hFFFF};

  // reset pin drive timing
  localparam int unsigned     CLK_PERIOD_NS   = 10;
  localparam int unsigned     RST_DRIVE_NS    = 320;
  localparam int unsigned     RST_DRIVE_CYC   = (RST_DRIVE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned     NUM_RST_SRC     = 3;

  typedef enum logic [1:0] {
    RST_IDLE    = 2'b00,
    RST_DRIVE   = 2'b01,
    RST_RELEASE = 2'b11
  } rst_state_type;

endpackage

// ---- logic/memory_map_address_decoder.sv ----
// address decoder and illegal-address reset for the 64 KB core bus
// assumes address and strobes are synchronous to core_clk; the reset pin has an external pull-up
//
// Summary of operation
// [R01] Addresses 0000 to 003F select the peripheral register page.
// [R02] An access to an unimplemented location raises an illegal-address reset.
// [R03] Software must not touch reserved locations; their effect is undefined.
// [R04] Addresses 0080 to 00FF select the 128-byte RAM.
// [R05] Addresses 7800 to 7FEE select the 2031-byte user flash.
// [R06] Addresses F000 to F2EF select monitor ROM; 768 bytes across both ranges.
// [R07] Fourteen bytes of flash vectors sit at the top of the map.
// [R08] FE00, FE01, FE02 select break status, reset status, break flag control.
// [R09] FE08 selects flash control; FFF0 selects flash block protect.
// [R10] FE0C, FE0D select breakpoint address high/low; FE0E breakpoint status/control.
// [R11] FE0F selects low-voltage status; FFFF selects watchdog control (writes only; a read of FFFF selects the vector).
// [R12] 7FEF is the trim byte, never decoded as user flash.
// [R13] A low reset pin puts the device in its startup state.
// [R14] The reset pin is driven low while any internal reset source is active.
// [R15] FEF0 to FEFF select monitor ROM; FFF2 to FFFF select flash vectors (a write to FFFF selects watchdog control instead).
// [R16] Each access gives exactly one select or illegal, from address and strobe alone.
`timescale 1ns/1ns
module memory_map_address_decoder
  import memmap_pkg::*;
#(
  parameter int unsigned DRIVE_CYCLES = memmap_pkg::RST_DRIVE_CYC,
  parameter int unsigned NUM_SRC      = memmap_pkg::NUM_RST_SRC
) (
  input  wire logic                                   core_clk,        // bus clock
  input  wire logic                                   arst_n,          // power-on reset, async
  input  wire logic [memmap_pkg::ADDR_W-1:0]          bus_addr,        // core address
  input  wire logic                                   bus_rd,          // read strobe
  input  wire logic                                   bus_wr,          // write strobe
  input  wire logic [NUM_SRC-1:0]                     int_rst_src,     // other internal reset sources
  input  wire logic                                   rst_pin_in,      // reset pin level
  output logic                                        rst_pin_out,     // reset pin drive value
  output logic                                        rst_pin_oe,      // reset pin drive enable
  output logic                                        sys_rst_n,       // reset to the rest of the chip
  output logic                                        illegal_rst_cause, // last reset from bad address
  output logic                                        sel_io,          // register page select
  output logic                                        sel_ram,         // RAM select
  output logic                                        sel_flash,       // user flash select
  output logic                                        sel_trim,        // trim byte select
  output logic                                        sel_monrom,      // monitor ROM select
  output logic                                        sel_vector,      // flash vector select
  output logic                                        sel_sysreg,      // high-page register select
  output logic                                        sel_reserved,    // reserved location
  output logic                                        illegal_addr,    // unimplemented location
  output logic [memmap_pkg::SYSREG_IDX_W-1:0]         sysreg_idx,      // which high-page register
  output logic [memmap_pkg::RAM_OFS_W-1:0]            ram_ofs,         // RAM byte offset
  output logic [memmap_pkg::FLASH_OFS_W-1:0]          flash_ofs,       // flash byte offset
  output logic [memmap_pkg::MONROM_OFS_W-1:0]         monrom_ofs,      // monitor ROM byte offset
  output logic [memmap_pkg::VECTOR_OFS_W-1:0]         vector_ofs       // vector byte offset
);
  import memmap_pkg::*;

  logic                     access;
  logic [SYSREG_NUM-1:0]    sysreg_hit;
  logic                     in_mon_lo;
  logic                     in_mon_hi;
  logic                     in_vec;
  rst_state_type            state_r;
  rst_state_type            state_nxt;
  logic [15:0]              drive_cnt_r;
  logic                     drive_done;
  logic                     any_int_src;
  logic                     illegal_start;
  logic                     sys_rst_n_r;
  logic                     cause_r;

  assign access = bus_rd | bus_wr;

  // one comparator per high-page register; FFFF doubles as the top vector byte,
  // so only writes reach the watchdog control register there
  genvar gi;
  generate
    for (gi = 0; gi < SYSREG_NUM; gi++) begin : g_sysreg
      if (gi == IDX_WDOG_CTL) begin : g_wdog
        assign sysreg_hit[gi] = (bus_addr == SYSREG_ADDR[gi]) && bus_wr; // R11
      end else begin : g_plain
        assign sysreg_hit[gi] = (bus_addr == SYSREG_ADDR[gi]); // R08 R09 R10 R11
      end
    end
  endgenerate

  assign in_mon_lo = (bus_addr >= MONROM_BASE) && (bus_addr <= MONROM_END); // R06
  assign in_mon_hi = (bus_addr >= MONROM2_BASE) && (bus_addr <= MONROM2_END); // R15
  assign in_vec    = (bus_addr >= VECTOR_BASE) && (bus_addr <= VECTOR_END) && !sysreg_hit[IDX_WDOG_CTL]; // R07 R15

  // pure address decode, no state, so the select is valid in the strobe cycle
  always_comb begin
    sel_io       = 1'b0;
    sel_ram      = 1'b0;
    sel_flash    = 1'b0;
    sel_trim     = 1'b0;
    sel_monrom   = 1'b0;
    sel_vector   = 1'b0;
    sel_sysreg   = 1'b0;
    sel_reserved = 1'b0;
    illegal_addr = 1'b0;
    sysreg_idx   = '0;
    if (access) begin // R16
      if (bus_addr <= IO_END) begin
        sel_io = 1'b1; // R01
      end else if ((bus_addr >= RAM_BASE) && (bus_addr <= RAM_END)) begin
        sel_ram = 1'b1; // R04
      end else if ((bus_addr >= FLASH_BASE) && (bus_addr <= FLASH_END)) begin
        sel_flash = 1'b1; // R05
      end else if (bus_addr == TRIM_ADDR) begin
        sel_trim = 1'b1; // R12
      end else if (in_mon_lo || in_mon_hi) begin
        sel_monrom = 1'b1; // R06 R15
      end else if (|sysreg_hit) begin
        sel_sysreg = 1'b1;
      end else if (in_vec) begin
        sel_vector = 1'b1; // R07
      end else if (((bus_addr >= RSVD_A_BASE) && (bus_addr <= RSVD_A_END)) ||
                   (bus_addr == RSVD_B_ADDR) || (bus_addr == RSVD_C_ADDR)) begin
        sel_reserved = 1'b1; // R03
      end else begin
        illegal_addr = 1'b1; // R02
      end
    end
    for (int i = 0; i < SYSREG_NUM; i++) begin
      if (sysreg_hit[i]) begin
        sysreg_idx = SYSREG_IDX_W'(i);
      end
    end
  end

  // byte offsets into each array; meaningful only while its select is high
  assign ram_ofs    = bus_addr[RAM_OFS_W-1:0];
  assign flash_ofs  = FLASH_OFS_W'(bus_addr - FLASH_BASE);
  assign monrom_ofs = in_mon_lo ? MONROM_OFS_W'(bus_addr - MONROM_BASE)
                                : MONROM_OFS_W'(MONROM_LO_BYTES + 32'(bus_addr[3:0])); // R06 R15
  assign vector_ofs = VECTOR_OFS_W'(bus_addr - VECTOR_BASE);

  // reset pin sequencer
  assign any_int_src   = |int_rst_src;
  assign illegal_start = illegal_addr && (state_r == RST_IDLE);
  assign drive_done    = (drive_cnt_r == 16'(DRIVE_CYCLES - 1)) && !any_int_src;

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RST_IDLE: begin
        if (illegal_start || any_int_src) begin
          state_nxt = RST_DRIVE; // R02 R14
        end
      end
      RST_DRIVE: begin
        if (drive_done) begin
          state_nxt = RST_RELEASE;
        end
      end
      RST_RELEASE: begin
        // wait for the pull-up so our own drive is not mistaken for an external reset
        if (rst_pin_in) begin
          state_nxt = RST_IDLE;
        end
      end
      default: state_nxt = RST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= RST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // counter restarts while any source holds, so the pin stays low for the full count after it ends
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      drive_cnt_r <= 16'h0000;
    end else if ((state_r != RST_DRIVE) || any_int_src) begin
      drive_cnt_r <= 16'h0000;
    end else if (!drive_done) begin
      drive_cnt_r <= drive_cnt_r + 16'h0001;
    end
  end

  assign rst_pin_oe  = (state_r == RST_DRIVE); // R14
  assign rst_pin_out = 1'b0;

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sys_rst_n_r <= 1'b0;
    end else begin
      sys_rst_n_r <= rst_pin_in && (state_r != RST_DRIVE); // R13
    end
  end
  assign sys_rst_n = sys_rst_n_r;

  // cause flag survives the reset it reports; a start of the illegal sequence wins over a clear
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cause_r <= 1'b0;
    end else if (illegal_start) begin
      cause_r <= 1'b1;
    end else if ((state_r == RST_IDLE) && (any_int_src || !rst_pin_in)) begin
      cause_r <= 1'b0;
    end
  end
  assign illegal_rst_cause = cause_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence illegal_hit_s;
    illegal_addr && (state_r == RST_IDLE);
  endsequence

  sequence pin_held_s;
    rst_pin_oe && !rst_pin_out ##1 rst_pin_oe && !sys_rst_n;
  endsequence

  io_page_a: assert property (access && (bus_addr <= IO_END) |-> sel_io) // R01
    else $error("register page not selected");

  hole_illegal_a: assert property (access && (bus_addr >= 16'h0040) && (bus_addr < RAM_BASE)
                                   |-> illegal_addr && !sel_io && !sel_ram) // R02
    else $error("unimplemented hole not flagged");

  ram_window_a: assert property (sel_ram |-> (bus_addr >= RAM_BASE) && (bus_addr <= RAM_END)
                                 && (ram_ofs == bus_addr[6:0])) // R04
    else $error("bad RAM decode");

  flash_window_a: assert property (sel_flash |-> (bus_addr >= FLASH_BASE) && (bus_addr <= FLASH_END)
                                   && (flash_ofs < 11'(FLASH_BYTES))) // R05
    else $error("bad flash decode");

  monrom_span_a: assert property (sel_monrom |-> (in_mon_lo || in_mon_hi)
                                  && (monrom_ofs < 10'(MONROM_BYTES))
                                  && (in_mon_hi == (monrom_ofs >= 10'(MONROM_LO_BYTES)))) // R06
    else $error("bad monitor ROM decode");

  vector_top_a: assert property (bus_rd && !bus_wr && (bus_addr >= VECTOR_BASE)
                                 |-> sel_vector && (vector_ofs == 4'(bus_addr - VECTOR_BASE))
                                 && (vector_ofs < 4'(VECTOR_BYTES))) // R07
    else $error("vector not selected");

  sys_regs_a: assert property (access && (bus_addr == 16'hFE01)
                               |-> sel_sysreg && (sysreg_idx == IDX_RESET_STATUS)) // R08
    else $error("reset status register not selected");

  flash_regs_a: assert property (access && (bus_addr == 16'hFFF0)
                                 |-> sel_sysreg && (sysreg_idx == IDX_FLASH_PROTECT)) // R09
    else $error("flash protect register not selected");

  brkpt_regs_a: assert property (access && (bus_addr == 16'hFE0E)
                                 |-> sel_sysreg && (sysreg_idx == IDX_BRKPT_STATCTL)) // R10
    else $error("breakpoint control not selected");

  wdog_ctl_a: assert property (bus_wr && (bus_addr == 16'hFFFF)
                               |-> sel_sysreg && !sel_vector && (sysreg_idx == IDX_WDOG_CTL)) // R11
    else $error("watchdog control not selected");

  trim_byte_a: assert property (access && (bus_addr == TRIM_ADDR) |-> sel_trim && !sel_flash) // R12
    else $error("trim byte decoded as flash");

  pin_reset_a: assert property (!rst_pin_in |=> !sys_rst_n) // R13
    else $error("pin low did not reset");

  illegal_drive_a: assert property (illegal_hit_s |=> pin_held_s ##1 illegal_rst_cause) // R02 R14
    else $error("illegal access did not drive reset pin");

  src_drive_a: assert property (any_int_src && (state_r == RST_IDLE) |=> rst_pin_oe) // R14
    else $error("internal source did not drive reset pin");

  drive_length_a: assert property ($fell(rst_pin_oe) |-> $past(drive_cnt_r) == 16'(DRIVE_CYCLES - 1)) // R14
    else $error("reset pin released early");

  monrom_high_a: assert property (access && (bus_addr >= MONROM2_BASE) && (bus_addr <= MONROM2_END)
                                  |-> sel_monrom && (monrom_ofs[3:0] == bus_addr[3:0])) // R15
    else $error("upper monitor ROM not selected");

  one_select_a: assert property (access |-> $onehot({sel_io, sel_ram, sel_flash, sel_trim, sel_monrom,
                                 sel_vector, sel_sysreg, sel_reserved, illegal_addr})) // R16
    else $error("select not one-hot");

  idle_quiet_a: assert property (!access |-> !illegal_addr && !sel_io && !sel_ram && !sel_sysreg) // R16
    else $error("select without strobe");

endmodule

// ---- tb/cpu_bus_model.sv ----
// cpu side of the core bus: issues byte accesses to the address decoder
// assumes core_clk comes from the bench; every access is launched on the falling edge
`timescale 1ns/1ns
module cpu_bus_model
  import memmap_pkg::*;
(
  input  wire logic                      core_clk, // bus clock
  output logic [memmap_pkg::ADDR_W-1:0]  bus_addr, // byte address
  output logic                           bus_rd,   // read strobe
  output logic                           bus_wr    // write strobe
);
  initial begin
    bus_addr = 16'h5A5A;
    bus_rd   = 1'b0;
    bus_wr   = 1'b0;
  end

  function automatic bit is_rsvd(input logic [15:0] a);
    return (a >= RSVD_A_BASE && a <= RSVD_A_END) || a == RSVD_B_ADDR || a == RSVD_C_ADDR;
  endfunction

  // strobe stands until the next start or release
  task automatic start(input logic [15:0] a, input logic rd, input logic wr, input bit rsvd_ok);
    @(negedge core_clk);
    if (is_rsvd(a) && !rsvd_ok) begin
      return;
    end
    bus_addr = a;
    bus_rd   = rd;
    bus_wr   = wr;
  endtask

  // a released address is not held, so stale decodes cannot pass by luck
  task automatic idle_bus();
    @(negedge core_clk);
    bus_rd   = 1'b0;
    bus_wr   = 1'b0;
    bus_addr = ~bus_addr;
  endtask
endmodule

// ---- tb/tb_memory_map_address_decoder.sv ----
// self-checking bench for the address decoder and its illegal-address reset
// assumes a pull-up on the reset pin; drive window shortened to DRV cycles
`timescale 1ns/1ns
module tb_memory_map_address_decoder;
  import memmap_pkg::*;
  localparam int unsigned DRV = 4;
  logic        core_clk, arst_n, ext_rst_n, rst_pin_in, rst_pin_out, rst_pin_oe, sys_rst_n, illegal_rst_cause;
  logic [15:0] bus_addr;
  logic        bus_rd, bus_wr, sel_io, sel_ram, sel_flash, sel_trim, sel_monrom, sel_vector;
  logic        sel_sysreg, sel_reserved, illegal_addr;
  logic [2:0]  int_rst_src;
  logic [3:0]  sysreg_idx, vector_ofs;
  logic [6:0]  ram_ofs;
  logic [10:0] flash_ofs;
  logic [9:0]  monrom_ofs;
  int          failures, checks_done;
  localparam logic [15:0] ADDRS [40] = '{16'h0000, 16'h003F, 16'h0040, 16'h007F, 16'h0080, 16'h00FF, 16'h0100,
    16'h77FF, 16'h7800, 16'h7FEE, 16'h7FEF, 16'h7FF0, 16'hEFFF, 16'hF000, 16'hF2EF, 16'hF2F0, 16'hFDFF,
    16'hFE00, 16'hFE01, 16'hFE02, 16'hFE03, 16'hFE06, 16'hFE07, 16'hFE08, 16'hFE09, 16'hFE0A, 16'hFE0C,
    16'hFE0D, 16'hFE0E, 16'hFE0F, 16'hFE10, 16'hFEF0, 16'hFEFF, 16'hFF00, 16'hFFEF, 16'hFFF0, 16'hFFF1,
    16'hFFF2, 16'hFFFE, 16'hFFFF};

  // pin is low when the device pulls it or the outside party does
  assign rst_pin_in = (rst_pin_oe === 1'b1 && rst_pin_out === 1'b0) ? 1'b0 : ext_rst_n;

  cpu_bus_model CPU (.core_clk(core_clk), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr));

  memory_map_address_decoder #(.DRIVE_CYCLES(DRV), .NUM_SRC(3)) DUT (
    .core_clk(core_clk), .arst_n(arst_n), .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr),
    .int_rst_src(int_rst_src), .rst_pin_in(rst_pin_in), .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .sys_rst_n(sys_rst_n), .illegal_rst_cause(illegal_rst_cause), .sel_io(sel_io), .sel_ram(sel_ram),
    .sel_flash(sel_flash), .sel_trim(sel_trim), .sel_monrom(sel_monrom), .sel_vector(sel_vector),
    .sel_sysreg(sel_sysreg), .sel_reserved(sel_reserved), .illegal_addr(illegal_addr),
    .sysreg_idx(sysreg_idx), .ram_ofs(ram_ofs), .flash_ofs(flash_ofs), .monrom_ofs(monrom_ofs),
    .vector_ofs(vector_ofs));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic chk_sel(input logic [8:0] got, input logic [8:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t select %b expected %b at %h", $time, got, exp, bus_addr);
    end
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t %s is %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // order: io ram flash trim monrom vector sysreg reserved illegal
  function automatic logic [8:0] exp_sel(input logic [15:0] a, input logic wr);
    if (a <= IO_END) return 9'h100;
    if (a >= RAM_BASE && a <= RAM_END) return 9'h080;
    if (a >= FLASH_BASE && a <= FLASH_END) return 9'h040;
    if (a == TRIM_ADDR) return 9'h020;
    if ((a >= MONROM_BASE && a <= MONROM_END) || (a >= MONROM2_BASE && a <= MONROM2_END)) return 9'h010;
    if (a == VECTOR_END && wr) return 9'h004;
    if (a >= VECTOR_BASE) return 9'h008;
    for (int i = 0; i < SYSREG_NUM; i++) if (a == SYSREG_ADDR[i]) return 9'h004;
    if ((a >= RSVD_A_BASE && a <= RSVD_A_END) || a == RSVD_B_ADDR || a == RSVD_C_ADDR) return 9'h002;
    return 9'h001;
  endfunction

  function automatic logic [8:0] got_sel();
    return {sel_io, sel_ram, sel_flash, sel_trim, sel_monrom, sel_vector, sel_sysreg, sel_reserved, illegal_addr};
  endfunction

  task automatic access_check(input logic [15:0] a, input logic rd, input logic wr);
    logic [8:0] e;
    logic [15:0] ix;
    e = exp_sel(a, wr);
    ix = 16'h0000;
    CPU.start(a, rd, wr, 1'b1);
    #1;
    chk_sel(got_sel(), e);
    for (int i = 0; i < SYSREG_NUM; i++) if (a == SYSREG_ADDR[i]) ix = 16'(i);
    case (e)
      9'h080: chk_val(16'(ram_ofs), 16'(a[6:0]), "ram offset");
      9'h040: chk_val(16'(flash_ofs), a - FLASH_BASE, "flash offset");
      9'h008: chk_val(16'(vector_ofs), a - VECTOR_BASE, "vector offset");
      9'h004: chk_val(16'(sysreg_idx), ix, "register index");
      9'h010: chk_val(16'(monrom_ofs), (a >= MONROM2_BASE) ? 16'(MONROM_LO_BYTES) + 16'(a[3:0])
                                                           : a - MONROM_BASE, "rom offset");
      default: ;
    endcase
  endtask

  task automatic wait_idle();
    for (int n = 0; n < 200 && !(sys_rst_n === 1'b1 && rst_pin_oe === 1'b0); n++) @(negedge core_clk);
    repeat (3) @(negedge core_clk);
  endtask

  // every boundary read and written, FFFF with both strobes; then no strobe at all
  task automatic t_region_sweep();
    for (int k = 0; k < 40; k++) begin
      access_check(ADDRS[k], 1'b1, 1'b0);
      access_check(ADDRS[k], 1'b0, 1'b1);
    end
    access_check(16'hFFFF, 1'b1, 1'b1);
    CPU.idle_bus();
    #1;
    chk_sel(got_sel(), 9'h000);
    wait_idle();
  endtask

  // measures how long the pin is driven and when chip reset lifts;
  // pre driven cycles have already gone by when the caller hands over
  task automatic check_drive(input logic cause, input int pre);
    int cnt;
    @(negedge core_clk);
    chk_val(16'(rst_pin_oe), 16'h0001, "pin drive");
    chk_val(16'(rst_pin_out), 16'h0000, "pin drive level");
    chk_val(16'(illegal_rst_cause), 16'(cause), "cause flag");
    cnt = pre;
    while (rst_pin_oe === 1'b1 && cnt < 60) begin
      if (cnt == 2) chk_val(16'(sys_rst_n), 16'h0000, "chip reset");
      cnt++;
      @(negedge core_clk);
    end
    chk_val(16'(cnt), 16'(DRV), "drive length");
    chk_val(16'(sys_rst_n), 16'h0000, "chip reset held");
    @(negedge core_clk);
    chk_val(16'(sys_rst_n), 16'h0001, "chip reset lift");
  endtask

  task automatic t_illegal_reset();
    CPU.start(16'h0050, 1'b1, 1'b0, 1'b1);
    CPU.start(16'h0060, 1'b1, 1'b0, 1'b1);
    CPU.idle_bus();
    check_drive(1'b1, 2);
    wait_idle();
  endtask

  task automatic t_source_resets();
    for (int b = 0; b < 3; b++) begin
      @(negedge core_clk);
      int_rst_src = 3'(1 << b);
      @(negedge core_clk);
      int_rst_src = 3'h0;
      chk_val(16'(rst_pin_oe), 16'h0001, "pin drive on source");
      check_drive(1'b0, 1);
      wait_idle();
    end
  endtask

  task automatic t_pin_reset();
    @(negedge core_clk);
    ext_rst_n = 1'b0;
    repeat (5) begin
      @(negedge core_clk);
      chk_val(16'(sys_rst_n), 16'h0000, "pin reset");
    end
    ext_rst_n = 1'b1;
    @(negedge core_clk);
    chk_val(16'(sys_rst_n), 16'h0001, "pin reset lift");
    chk_val(16'(illegal_rst_cause), 16'h0000, "cause after pin");
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    arst_n = 1'b0;
    ext_rst_n = 1'b1;
    int_rst_src = 3'h0;
    repeat (6) @(negedge core_clk);
    chk_val(16'(sys_rst_n), 16'h0000, "reset hold");
    chk_val(16'(rst_pin_oe), 16'h0000, "no drive in reset");
    arst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    chk_val(16'(sys_rst_n), 16'h0001, "out of reset");
    t_region_sweep();
    t_illegal_reset();
    t_source_resets();
    t_illegal_reset();
    t_pin_reset();
    wrap_up();
  end

  // sweep and resets take a few hundred cycles at most
  initial begin
    #200000;
    failures++;
    wrap_up();
  end
endmodule
